/* File: tacd_params.svh */
// constants for the trace address/context and atom decoder
`ifndef TACD_PARAMS_SVH
`define TACD_PARAMS_SVH

// ==================================================
// address-with-context headers
`define TACD_HDR_IS0_SHORT 8'h82
`define TACD_HDR_IS1_SHORT 8'h83
`define TACD_HDR_IS0_LONG  8'h85
`define TACD_HDR_IS1_LONG  8'h86
`define TACD_SHORT_BYTES   4'h4
`define TACD_LONG_BYTES    4'h8
`define TACD_SHORT_CLR     64'h0000_0000_0fff_ffff
`define TACD_IS_ZERO       2'h0
`define TACD_IS_ONE        2'h1

// ==================================================
// context information byte fields
`define TACD_CTX_C_BIT     7
`define TACD_CTX_V_BIT     6
`define TACD_CTX_NS_BIT    5
`define TACD_CTX_SF_BIT    4
`define TACD_CTX_EL_HI     1
`define TACD_CTX_EL_LO     0
`define TACD_CTXID_BYTES   4'h4
`define TACD_VMW_8         5'h01
`define TACD_VMW_16        5'h02
`define TACD_VMW_32        5'h04

// ==================================================
// atom header patterns
`define TACD_F1_TOP        7'h7b
`define TACD_F2_TOP        6'h36
`define TACD_F3_TOP        5'h1f
`define TACD_F4_TOP        6'h37
`define TACD_F5_SOLO       8'hf5
`define TACD_F5_LO         8'hd5
`define TACD_F5_HI         8'hd7
`define TACD_F6A_LO        8'hc0
`define TACD_F6A_HI        8'hd4
`define TACD_F6B_LO        8'he0
`define TACD_F6B_HI        8'hf4
`define TACD_F6_BASE       5'h04
`define TACD_F4_SEQ_00     24'h00000e
`define TACD_F4_SEQ_10     24'h00000a
`define TACD_F4_SEQ_11     24'h000005
`define TACD_F5_SEQ_101    24'h00001e
`define TACD_F5_SEQ_010    24'h00000a
`define TACD_F5_SEQ_011    24'h000015
`define TACD_CNT_1         5'h01
`define TACD_CNT_2         5'h02
`define TACD_CNT_3         5'h03
`define TACD_CNT_4         5'h04
`define TACD_CNT_5         5'h05

// ==================================================
// speculation tracking widths
`define TACD_KEY_W         8
`define TACD_DEPTH_W       8

`endif

/* File: tacd_pkg.sv */
// types shared by the trace decoder files
package tacd_pkg;
	// parser states
	typedef enum logic [2:0] {
		TACD_ST_HDR,
		TACD_ST_ADDR,
		TACD_ST_CTX,
		TACD_ST_VMID,
		TACD_ST_CTXID,
		TACD_ST_FIN,
		TACD_ST_ATOM
	} tacd_state_t;
	// instruction set code of an address entry
	typedef logic [1:0] tacd_is_t;
endpackage

/* File: tacd_atom_if.sv */
// link between the byte parser and the atom tracking unit
`timescale 1ns/1ps
`default_nettype none
`include "tacd_params.svh"
interface tacd_atom_if;
	logic                       go;          // one atom this cycle
	logic                       taken;       // e status of that atom
	logic                       elem_valid;  // atom element out
	logic                       elem_taken;  // its e status
	logic [`TACD_KEY_W-1:0]     elem_key;    // its speculation key
	logic                       commit;      // implied commit of one
	logic [`TACD_DEPTH_W-1:0]   depth;       // current depth
	modport parser (output go, output taken, input elem_valid, input elem_taken,
		input elem_key, input commit, input depth);
	modport unit (input go, input taken, output elem_valid, output elem_taken,
		output elem_key, output commit, output depth);
endinterface
`default_nettype wire

/* File: tacd_atom_unit.sv */
// speculation key and depth tracking for atom elements
`timescale 1ns/1ps
`default_nettype none
`include "tacd_params.svh"
module tacd_atom_unit (
	// clock and reset
	input  wire logic                     i_core_clk,
	input  wire logic                     i_reset,
	// limits
	input  wire logic [`TACD_KEY_W-1:0]   i_spec_key_limit,
	input  wire logic [`TACD_DEPTH_W-1:0] i_max_spec_depth,
	// parser side
	tacd_atom_if.unit                     atom
);
	import tacd_pkg::*;

	// ==================================================
	// state
	logic [`TACD_KEY_W-1:0]   key_r;      // speculation key
	logic [`TACD_KEY_W-1:0]   key_inc;    // key plus one
	logic [`TACD_KEY_W-1:0]   key_nxt;    // wrapped key
	logic [`TACD_DEPTH_W-1:0] depth_r;    // speculation depth
	logic [`TACD_DEPTH_W-1:0] depth_inc;  // depth plus one
	logic                     over;       // limit exceeded

	assign key_inc   = key_r + `TACD_KEY_W'(1);
	assign key_nxt   = (key_inc >= i_spec_key_limit) ? '0 : key_inc;
	assign depth_inc = depth_r + `TACD_DEPTH_W'(1);
	assign over      = depth_inc > i_max_spec_depth;
	assign atom.depth = depth_r;

	// ==================================================
	// element and commit registers
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			key_r           <= '0;
			depth_r         <= '0;
			atom.elem_valid <= 1'b0;
			atom.elem_taken <= 1'b0;
			atom.elem_key   <= '0;
			atom.commit     <= 1'b0;
		end else begin
			atom.elem_valid <= atom.go;
			atom.commit     <= atom.go && over;
			if (atom.go) begin
				atom.elem_taken <= atom.taken;
				atom.elem_key   <= key_r;
				key_r           <= key_nxt;
				depth_r         <= over ? depth_r : depth_inc;
			end
		end
	end

	// ==================================================
	// checks
	a_elem_key_tag: assert property (@(posedge i_core_clk) disable iff (i_reset)
		atom.go |=> atom.elem_valid && atom.elem_key == $past(key_r))
		else $error("atom element key not the current key");
	a_key_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!atom.go |=> $stable(key_r) && !atom.elem_valid)
		else $error("key moved without an atom");
	a_depth_commit: assert property (@(posedge i_core_clk) disable iff (i_reset)
		atom.go && depth_r >= i_max_spec_depth |=> atom.commit && $stable(depth_r))
		else $error("depth over limit without commit");
	a_depth_rise: assert property (@(posedge i_core_clk) disable iff (i_reset)
		atom.go && depth_r < i_max_spec_depth |=> !atom.commit && depth_r == $past(depth_r) + 8'h01)
		else $error("depth did not rise by one");
endmodule
`default_nettype wire

/* File: tacd_decoder.sv */
// byte stream decoder for address-with-context and atom trace packets
`timescale 1ns/1ps
`default_nettype none
`include "tacd_params.svh"
// Behaviour
// - vmid absent or zero when feature off
// - context bit adds four context-id bytes
// - context id absent or zero when off
// - vmid width 8/16/32 from width code
// - take level, security, wide flag; emit
// - header 82: set 00, bits 31:2
// - header 83: set 01, bits 31:1
// - header 85: set 0, bits 63:2
// - header 86: set 1, bits 63:1
// - emit address, shift three-entry queue
// - branches, barriers, traced transfers make atoms
// - branch: e taken, n not taken
// - traced loads and stores: e only
// - barrier: e means synchronisation happened
// - other conditionals make no atoms
// - six atom formats, header byte only
// - formats one, two, three headers
// - formats four and five headers
// - format six: four to 24 atoms
// - atom tagged with key, key wraps
// - depth over maximum implies one commit
// - vmid-present bit selects vmid section
// - uncarried bits kept; set 0 low zero
module tacd_decoder (
	// clock and reset
	input  wire logic                     i_core_clk,
	input  wire logic                     i_reset,
	// trace byte stream
	input  wire logic                     i_byte_valid,
	input  wire logic [7:0]               i_byte,
	output logic                          o_byte_ready,
	// configuration
	input  wire logic                     i_emit_en,
	input  wire logic [4:0]               i_vm_tag_width_code,
	input  wire logic [`TACD_KEY_W-1:0]   i_spec_key_limit,
	input  wire logic [`TACD_DEPTH_W-1:0] i_max_spec_depth,
	// address element and queue
	output logic                          o_addr_valid,
	output logic [63:0]                   o_q0_addr,
	output tacd_pkg::tacd_is_t            o_q0_is,
	output logic [63:0]                   o_q1_addr,
	output tacd_pkg::tacd_is_t            o_q1_is,
	output logic [63:0]                   o_q2_addr,
	output tacd_pkg::tacd_is_t            o_q2_is,
	// context element
	output logic                          o_ctx_valid,
	output logic [31:0]                   o_ctx_tag_value,
	output logic [31:0]                   o_vm_tag_value,
	output logic [1:0]                    o_exception_level,
	output logic                          o_security_bit,
	output logic                          o_wide_state_flag,
	// atom elements
	output logic                          o_atom_valid,
	output logic                          o_atom_taken,
	output logic [`TACD_KEY_W-1:0]        o_speculation_key,
	output logic                          o_commit_valid,
	output logic [`TACD_DEPTH_W-1:0]      o_spec_depth
);
	import tacd_pkg::*;

	// ==================================================
	// state and storage
	tacd_state_t  state_r;       // parser state
	tacd_state_t  state_nxt;     // next parser state
	logic [3:0]   idx_r;         // byte index in a section
	logic [3:0]   idx_nxt;       // next byte index
	logic [7:0]   hdr_r;         // address packet header
	logic [63:0]  raw_r;         // address bytes as received
	logic [7:0]   ctxb_r;        // context information byte
	logic [31:0]  vm_asm_r;      // vmid bytes as received
	logic [31:0]  cid_asm_r;     // context id bytes as received
	logic [23:0]  atom_bits_r;   // pending atoms, oldest in bit 0
	logic [4:0]   atom_cnt_r;    // pending atom count
	tacd_atom_if  atom ();       // link to tracking unit

	// ==================================================
	// handshake and byte index
	logic         take;          // byte accepted this cycle
	logic         sec_last;      // last byte of current section
	logic [3:0]   addr_len;      // address section length
	logic [3:0]   vm_len;        // vmid section length
	logic         long_hdr;      // eight address bytes
	logic         is1_hdr;       // set one header

	assign o_byte_ready = (state_r != TACD_ST_FIN) && (state_r != TACD_ST_ATOM);
	assign take         = i_byte_valid && o_byte_ready;
	assign long_hdr     = (hdr_r == `TACD_HDR_IS0_LONG) || (hdr_r == `TACD_HDR_IS1_LONG);
	assign is1_hdr      = (hdr_r == `TACD_HDR_IS1_SHORT) || (hdr_r == `TACD_HDR_IS1_LONG);
	assign addr_len     = long_hdr ? `TACD_LONG_BYTES : `TACD_SHORT_BYTES;
	assign vm_len       = (i_vm_tag_width_code == `TACD_VMW_8)  ? 4'h1 :
	                      (i_vm_tag_width_code == `TACD_VMW_16) ? 4'h2 :
	                      (i_vm_tag_width_code == `TACD_VMW_32) ? 4'h4 : 4'h0;
	assign sec_last     = (state_r == TACD_ST_ADDR)  ? (idx_r == addr_len - 4'h1) :
	                      (state_r == TACD_ST_VMID)  ? (idx_r == vm_len - 4'h1) :
	                      (idx_r == `TACD_CTXID_BYTES - 4'h1);

	// ==================================================
	// header classification
	logic         hdr_addr;      // address-with-context header
	logic         f1;            // one atom
	logic         f2;            // two atoms
	logic         f3;            // three atoms
	logic         f4;            // four atoms
	logic         f5;            // five atoms
	logic         f6;            // four to 24 atoms
	logic [4:0]   f6_cnt;        // format six total
	logic [23:0]  f6_ones;       // format six run of e atoms
	logic [23:0]  f6_bits;       // format six with final atom
	logic [23:0]  f4_bits;       // format four sequence
	logic [23:0]  f5_bits;       // format five sequence
	logic [23:0]  ld_bits;       // atoms to load
	logic [4:0]   ld_cnt;        // count to load
	logic         hdr_atom;      // any atom header

	assign hdr_addr = (i_byte == `TACD_HDR_IS0_SHORT) || (i_byte == `TACD_HDR_IS1_SHORT) ||
	                  (i_byte == `TACD_HDR_IS0_LONG)  || (i_byte == `TACD_HDR_IS1_LONG);
	assign f1 = i_byte[7:1] == `TACD_F1_TOP;
	assign f2 = i_byte[7:2] == `TACD_F2_TOP;
	assign f3 = i_byte[7:3] == `TACD_F3_TOP;
	assign f4 = i_byte[7:2] == `TACD_F4_TOP;
	assign f5 = (i_byte == `TACD_F5_SOLO) || (i_byte >= `TACD_F5_LO && i_byte <= `TACD_F5_HI);
	assign f6 = (i_byte >= `TACD_F6A_LO && i_byte <= `TACD_F6A_HI) ||
	            (i_byte >= `TACD_F6B_LO && i_byte <= `TACD_F6B_HI);
	assign hdr_atom = f1 || f2 || f3 || f4 || f5 || f6;

	// count plus three e atoms, then final
	assign f6_cnt  = i_byte[4:0] + `TACD_F6_BASE;
	assign f6_ones = ~({24{1'b1}} << f6_cnt);
	assign f6_bits = i_byte[5] ? (f6_ones & ~(24'h000001 << (f6_cnt - 5'h01))) : f6_ones;
	assign f4_bits = (i_byte[1:0] == 2'h0) ? `TACD_F4_SEQ_00 :
	                 (i_byte[1:0] == 2'h2) ? `TACD_F4_SEQ_10 :
	                 (i_byte[1:0] == 2'h3) ? `TACD_F4_SEQ_11 : 24'h000000;
	assign f5_bits = ({i_byte[5], i_byte[1:0]} == 3'h5) ? `TACD_F5_SEQ_101 :
	                 ({i_byte[5], i_byte[1:0]} == 3'h2) ? `TACD_F5_SEQ_010 :
	                 ({i_byte[5], i_byte[1:0]} == 3'h3) ? `TACD_F5_SEQ_011 : 24'h000000;
	assign ld_bits = f1 ? {23'h0, i_byte[0]} : f2 ? {22'h0, i_byte[1:0]} :
	                 f3 ? {21'h0, i_byte[2:0]} : f4 ? f4_bits : f5 ? f5_bits : f6_bits;
	assign ld_cnt  = f1 ? `TACD_CNT_1 : f2 ? `TACD_CNT_2 : f3 ? `TACD_CNT_3 :
	                 f4 ? `TACD_CNT_4 : f5 ? `TACD_CNT_5 : f6_cnt;

	// ==================================================
	// address assembly
	logic [31:0]  lo_is0;        // bits 31:2 for set zero
	logic [31:0]  lo_is1;        // bits 31:1 for set one
	logic [31:0]  lo32;          // chosen low word
	logic [63:0]  new_addr;      // decoded address
	tacd_is_t     new_is;        // decoded set code

	assign lo_is0 = {raw_r[31:16], raw_r[14:8], raw_r[6:0], 2'b00};
	assign lo_is1 = {raw_r[31:8], raw_r[6:0], 1'b0};
	assign lo32   = is1_hdr ? lo_is1 : lo_is0;
	assign new_addr = long_hdr ? {raw_r[63:32], lo32} : ((o_q0_addr & ~`TACD_SHORT_CLR) | {32'h0, lo32});
	assign new_is   = is1_hdr ? `TACD_IS_ONE : `TACD_IS_ZERO;

	// ==================================================
	// next parser state
	always_comb begin
		state_nxt = state_r;
		idx_nxt   = idx_r;
		unique case (state_r)
			TACD_ST_HDR: begin
				if (take && hdr_addr) begin
					state_nxt = TACD_ST_ADDR;
					idx_nxt   = 4'h0;
				end else if (take && hdr_atom) begin
					state_nxt = TACD_ST_ATOM;
				end
			end
			TACD_ST_ADDR: begin
				if (take) begin
					idx_nxt = sec_last ? 4'h0 : idx_r + 4'h1;
					if (sec_last) begin
						state_nxt = TACD_ST_CTX;
					end
				end
			end
			TACD_ST_CTX: begin
				// context id section only when flagged
				if (take) begin
					idx_nxt = 4'h0;
					if (i_byte[`TACD_CTX_V_BIT] && vm_len != 4'h0) begin
						state_nxt = TACD_ST_VMID;
					end else if (i_byte[`TACD_CTX_C_BIT]) begin
						state_nxt = TACD_ST_CTXID;
					end else begin
						state_nxt = TACD_ST_FIN;
					end
				end
			end
			TACD_ST_VMID: begin
				if (take) begin
					idx_nxt = sec_last ? 4'h0 : idx_r + 4'h1;
					if (sec_last) begin
						state_nxt = ctxb_r[`TACD_CTX_C_BIT] ? TACD_ST_CTXID : TACD_ST_FIN;
					end
				end
			end
			TACD_ST_CTXID: begin
				if (take) begin
					idx_nxt = sec_last ? 4'h0 : idx_r + 4'h1;
					if (sec_last) begin
						state_nxt = TACD_ST_FIN;
					end
				end
			end
			TACD_ST_FIN: begin
				state_nxt = TACD_ST_HDR;
			end
			TACD_ST_ATOM: begin
				if (atom_cnt_r == 5'h01) begin
					state_nxt = TACD_ST_HDR;
				end
			end
			default: begin
				state_nxt = TACD_ST_HDR;
			end
		endcase
	end

	// ==================================================
	// state register
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			state_r <= TACD_ST_HDR;
			idx_r   <= 4'h0;
		end else begin
			state_r <= state_nxt;
			idx_r   <= idx_nxt;
		end
	end

	// ==================================================
	// packet byte capture, least significant byte first
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			hdr_r     <= 8'h00;
			raw_r     <= 64'h0;
			ctxb_r    <= 8'h00;
			vm_asm_r  <= 32'h0;
			cid_asm_r <= 32'h0;
		end else if (take) begin
			unique case (state_r)
				TACD_ST_HDR:   hdr_r <= hdr_addr ? i_byte : hdr_r;
				TACD_ST_ADDR:  raw_r[idx_r[2:0]*8 +: 8] <= i_byte;
				TACD_ST_CTX:   ctxb_r <= i_byte;
				TACD_ST_VMID:  vm_asm_r[idx_r[1:0]*8 +: 8] <= i_byte;
				TACD_ST_CTXID: cid_asm_r[idx_r[1:0]*8 +: 8] <= i_byte;
				default:       hdr_r <= hdr_r;
			endcase
		end
	end

	// ==================================================
	// packet completion: context, address element, queue
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_addr_valid      <= 1'b0;
			o_ctx_valid       <= 1'b0;
			o_q0_addr         <= 64'h0;
			o_q1_addr         <= 64'h0;
			o_q2_addr         <= 64'h0;
			o_q0_is           <= `TACD_IS_ZERO;
			o_q1_is           <= `TACD_IS_ZERO;
			o_q2_is           <= `TACD_IS_ZERO;
			o_ctx_tag_value   <= 32'h0;
			o_vm_tag_value    <= 32'h0;
			o_exception_level <= 2'h0;
			o_security_bit    <= 1'b0;
			o_wide_state_flag <= 1'b0;
		end else begin
			o_addr_valid <= (state_r == TACD_ST_FIN) && i_emit_en;
			o_ctx_valid  <= (state_r == TACD_ST_FIN) && i_emit_en;
			if (state_r == TACD_ST_FIN) begin
				// zero field loaded like any other
				if (ctxb_r[`TACD_CTX_C_BIT]) begin
					o_ctx_tag_value <= cid_asm_r;
				end
				// zero field loaded like any other
				if (ctxb_r[`TACD_CTX_V_BIT]) begin
					if (i_vm_tag_width_code == `TACD_VMW_8) begin
						o_vm_tag_value[7:0] <= vm_asm_r[7:0];
					end else if (i_vm_tag_width_code == `TACD_VMW_16) begin
						o_vm_tag_value[15:0] <= vm_asm_r[15:0];
					end else if (i_vm_tag_width_code == `TACD_VMW_32) begin
						o_vm_tag_value <= vm_asm_r;
					end
				end
				o_exception_level <= ctxb_r[`TACD_CTX_EL_HI:`TACD_CTX_EL_LO];
				o_security_bit    <= ctxb_r[`TACD_CTX_NS_BIT];
				o_wide_state_flag <= ctxb_r[`TACD_CTX_SF_BIT];
				// shift queue, newest in entry 0
				o_q2_addr <= o_q1_addr;
				o_q2_is   <= o_q1_is;
				o_q1_addr <= o_q0_addr;
				o_q1_is   <= o_q0_is;
				o_q0_addr <= new_addr;
				o_q0_is   <= new_is;
			end
		end
	end

	// ==================================================
	// atom expansion, one atom per cycle
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			atom_bits_r <= 24'h0;
			atom_cnt_r  <= 5'h00;
		end else if (state_r == TACD_ST_HDR && take && hdr_atom) begin
			atom_bits_r <= ld_bits;
			atom_cnt_r  <= ld_cnt;
		end else if (state_r == TACD_ST_ATOM) begin
			atom_bits_r <= atom_bits_r >> 1;
			atom_cnt_r  <= atom_cnt_r - 5'h01;
		end
	end

	// one atom element per packet atom
	// loads and stores arrive as e
	assign atom.go    = state_r == TACD_ST_ATOM;
	assign atom.taken = atom_bits_r[0];

	// key and depth tracking
	tacd_atom_unit u_atom (
		.i_core_clk       (i_core_clk),
		.i_reset          (i_reset),
		.i_spec_key_limit (i_spec_key_limit),
		.i_max_spec_depth (i_max_spec_depth),
		.atom             (atom.unit)
	);

	assign o_atom_valid      = atom.elem_valid;
	assign o_atom_taken      = atom.elem_taken;
	assign o_speculation_key = atom.elem_key;
	assign o_commit_valid    = atom.commit;
	assign o_spec_depth      = atom.depth;

	// ==================================================
	// checks
	a_atom_stall: assert property (@(posedge i_core_clk) disable iff (i_reset)
		state_r == TACD_ST_ATOM |-> !o_byte_ready)
		else $error("byte taken while atoms pending");
	a_f1_single: assert property (@(posedge i_core_clk) disable iff (i_reset)
		state_r == TACD_ST_HDR && take && f1 |=> atom.go && atom.taken == $past(i_byte[0]) ##1 !atom.go)
		else $error("format one not a single atom");
	a_f4_four: assert property (@(posedge i_core_clk) disable iff (i_reset)
		state_r == TACD_ST_HDR && take && f4 |=> atom.go [*4] ##1 !atom.go)
		else $error("format four not four atoms");
	a_f6_min: assert property (@(posedge i_core_clk) disable iff (i_reset)
		state_r == TACD_ST_HDR && take && i_byte == `TACD_F6A_LO |=> (atom.go && atom.taken) [*4] ##1 !atom.go)
		else $error("shortest format six not four e atoms");
	a_queue_shift: assert property (@(posedge i_core_clk) disable iff (i_reset)
		state_r == TACD_ST_FIN |=> o_q1_addr == $past(o_q0_addr) && o_q2_addr == $past(o_q1_addr))
		else $error("address queue did not shift");
	a_is0_low: assert property (@(posedge i_core_clk) disable iff (i_reset)
		o_addr_valid && o_q0_is == `TACD_IS_ZERO |-> o_q0_addr[1:0] == 2'b00)
		else $error("set zero address has low bits set");
	a_emit_gate: assert property (@(posedge i_core_clk) disable iff (i_reset)
		state_r == TACD_ST_FIN |=> o_ctx_valid == $past(i_emit_en) && o_addr_valid == o_ctx_valid)
		else $error("element emission not gated by enable");
endmodule
`default_nettype wire

/* File: tacd_trace_src.sv */
// trace unit model: offers queued trace bytes to the decoder in order
`timescale 1ns/1ps
`default_nettype none
module tacd_trace_src (
	// clock and flow control
	input  wire logic i_core_clk,
	input  wire logic i_byte_ready,
	// byte stream out
	output logic      o_byte_valid,
	output logic [7:0] o_byte
);
	logic [7:0] q_r [$]; // bytes waiting to go out
	initial begin
		o_byte_valid = 1'b0;
		o_byte       = 8'h00;
	end
	always @(posedge i_core_clk) begin
		if (o_byte_valid && i_byte_ready)
			void'(q_r.pop_front());
		o_byte_valid <= (q_r.size() != 0);
		// idle line toggles so a stale byte never looks valid
		o_byte       <= (q_r.size() != 0) ? q_r[0] : ~o_byte;
	end
endmodule
`default_nettype wire

/* File: trace_addr_ctx_atom_decoder_tb_top.sv */
// self-checking bench for the trace packet decoder
`timescale 1ns/1ps
`default_nettype none
module trace_addr_ctx_atom_decoder_tb_top;
	logic        clk, rst, valid, ready, emit, av, cv, atv, tk, cm, ns, sf;
	logic [7:0]  byt, key, dep, lim, mdep;
	logic [4:0]  vmw;
	logic [1:0]  is0, is1, is2, el, eis [3]; // queue set codes seen and expected
	logic [31:0] cid, vid, ecid, evm;
	logic [63:0] q0, q1, q2, eq [3];
	logic [8:0]  seen [$];
	logic [0:23] exp_e = 24'b110010011101111111111110; // e status, oldest first
	logic [7:0]  atom_hdr [7] = '{8'hf7, 8'hd9, 8'hfa, 8'hdc, 8'hf5, 8'hc0, 8'he1};
	int          n_mismatch, total_checks, n_av, n_cv, n_cm, ena;
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	tacd_trace_src src (.i_core_clk(clk), .i_byte_ready(ready), .o_byte_valid(valid), .o_byte(byt));
	tacd_decoder DUT (.i_core_clk(clk), .i_reset(rst), .i_byte_valid(valid), .i_byte(byt), .o_byte_ready(ready),
		.i_emit_en(emit), .i_vm_tag_width_code(vmw), .i_spec_key_limit(lim), .i_max_spec_depth(mdep),
		.o_addr_valid(av), .o_q0_addr(q0), .o_q0_is(is0), .o_q1_addr(q1), .o_q1_is(is1), .o_q2_addr(q2),
		.o_q2_is(is2), .o_ctx_valid(cv), .o_ctx_tag_value(cid), .o_vm_tag_value(vid), .o_exception_level(el),
		.o_security_bit(ns), .o_wide_state_flag(sf), .o_atom_valid(atv), .o_atom_taken(tk),
		.o_speculation_key(key), .o_commit_valid(cm), .o_spec_depth(dep));
	// element monitor, sampled mid-cycle
	always @(negedge clk) begin
		if (av === 1'b1) n_av++;
		if (cv === 1'b1) n_cv++;
		if (cm === 1'b1) n_cm++;
		if (atv === 1'b1) seen.push_back({tk, key});
	end
	task automatic chk(input string what, input logic [63:0] seen_v, input logic [63:0] exp_v);
		total_checks++;
		if (seen_v !== exp_v) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp_v, seen_v);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// bounded wait until the model has handed over every byte
	task automatic drain();
		for (int k = 0; k < 80 && src.q_r.size() != 0; k++) @(negedge clk);
		if (src.q_r.size() != 0) begin
			n_mismatch++;
			close_out();
		end
	endtask
	task automatic send_addr(input logic [7:0] h, input logic [63:0] a, input logic [7:0] c, input logic [4:0] w,
			input logic [31:0] v, input logic [31:0] d, input logic e);
		int nv;
		logic s1;
		logic [7:0] b;
		logic [31:0] m;
		s1 = h[0] ^ h[2];
		nv = (w == 5'h01) ? 1 : (w == 5'h02) ? 2 : (w == 5'h04) ? 4 : 0;
		@(posedge clk);
		emit <= e;
		vmw  <= w;
		@(negedge clk);
		src.q_r.push_back(h);
		for (int i = 0; i < (h[2] ? 8 : 4); i++) begin
			b = a[8*i +: 8];
			if (i == 0) b = s1 ? {1'b0, a[7:1]} : {1'b0, a[8:2]};
			if (i == 1 && !s1) b = {1'b0, a[15:9]};
			src.q_r.push_back(b);
		end
		src.q_r.push_back(c);
		for (int j = 0; j < (c[6] ? nv : 0); j++) src.q_r.push_back(v[8*j +: 8]);
		for (int j = 0; j < (c[7] ? 4 : 0); j++) src.q_r.push_back(d[8*j +: 8]);
		m    = (nv == 1) ? 32'h0000_00ff : (nv == 2) ? 32'h0000_ffff : (nv == 4) ? 32'hffff_ffff : 32'h0;
		evm  = c[6] ? ((evm & ~m) | (v & m)) : evm;
		ecid = c[7] ? d : ecid;
		eq[2] = eq[1];
		eq[1] = eq[0];
		eq[0] = h[2] ? a : ((eq[0] & ~64'h0000_0000_0fff_ffff) | {32'h0, a[31:0]});
		eis[2] = eis[1];
		eis[1] = eis[0];
		eis[0] = {1'b0, s1};
		ena += e;
		drain();
		repeat (4) @(negedge clk);
		chk("q0_addr", q0, eq[0]);
		chk("q0_is", is0, {1'b0, s1});
		chk("q1_addr", q1, eq[1]);
		chk("q2_addr", q2, eq[2]);
		chk("q1_q2_is", {is1, is2}, {eis[1], eis[2]});
		chk("addr_pulses", n_av, ena);
		chk("ctx_pulses", n_cv, ena);
		chk("ctx_id", cid, ecid);
		chk("vm_id", vid, evm);
		chk("ctx_bits", {el, ns, sf}, {c[1:0], c[5], c[4]});
	endtask
	initial begin
		rst  = 1'b1;
		emit = 1'b1;
		vmw  = 5'h02;
		lim  = 8'h05;
		mdep = 8'h03;
		ecid = 32'h0;
		evm  = 32'h0;
		eq   = '{64'h0, 64'h0, 64'h0};
		eis  = '{2'h0, 2'h0, 2'h0};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("ready_rst", ready, 1'b1);
		chk("q0_rst", q0, 64'h0);
		send_addr(8'h86, 64'h1234_5678_9abc_def0, 8'hf2, 5'h02, 32'h0000_1234, 32'ha1b2_c3d4, 1'b1);
		send_addr(8'h82, 64'h0000_0000_8765_4320, 8'h41, 5'h04, 32'hdead_beef, 32'h0, 1'b1);
		send_addr(8'h83, 64'h0000_0000_0246_8ace, 8'h43, 5'h01, 32'h0000_005a, 32'h0, 1'b0);
		send_addr(8'h85, 64'hfedc_ba98_7654_3210, 8'h30, 5'h04, 32'h0, 32'h0, 1'b1);
		// atom stream of the six formats
		foreach (atom_hdr[i]) src.q_r.push_back(atom_hdr[i]);
		drain();
		repeat (8) @(negedge clk);
		chk("atom_count", seen.size(), 24);
		foreach (seen[i]) chk("atom", seen[i], {exp_e[i], 8'(i % 5)});
		chk("commits", n_cm, 21);
		chk("depth", dep, 8'h03);
		close_out();
	end
endmodule
`default_nettype wire
